/* File: design/dcc_checker.sv */
/*
 * Drive command checker: judges each command against the drive state and limits, answers with an error code,
 * keeps the latched signal status word and an interrupt.
 * Assumes drive status, limit values and event pulses come from logic on clk_sys; registers are reached over
 * a plain strobe port with read data one cycle after the read strobe.
 */
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "dcc_map.svh"

module dcc_checker #(
  parameter int VEL_W = 32
) (
  // Clock and reset.
  input  wire logic                   clk_sys,
  input  wire logic                   arst_n,
  // Command in and answer out.
  input  wire logic                   cmd_valid,
  input  wire dcc_pkg::dcc_cmd_t      cmd,
  input  wire dcc_pkg::dcc_data_t     cmd_data,
  output logic                        resp_valid,
  output dcc_pkg::dcc_resp_t          resp,
  // Drive status and limits.
  input  wire dcc_pkg::dcc_drive_t    drive,
  input  wire logic [VEL_W-1:0]       vel_max,
  input  wire logic [VEL_W-1:0]       tune_limit,
  // Event pulses from motion and homing logic.
  input  wire logic                   ev_range_exceeded,
  input  wire logic                   ev_tune_range,
  input  wire logic                   ev_pos_dev,
  input  wire logic                   ev_home_fail,
  input  wire logic [15:0]            ev_home_sub,
  input  wire logic                   ev_home_done,
  // Event error report.
  output logic                        event_valid,
  output dcc_pkg::dcc_resp_t          event_err,
  // Status.
  output logic                        zero_valid,
  output logic                        irq,
  // Register port.
  input  wire logic [3:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [31:0]                 reg_rdata
);

  logic [`DCC_SIG_WIDTH-1:0] latched_signal_status;
  logic [`DCC_SIG_WIDTH-1:0] sig_mask;
  logic [2:0]                position_deviation_response;
  logic [15:0]               home_sub_err;
  dcc_pkg::dcc_resp_t        next_resp;
  logic [`DCC_SIG_WIDTH-1:0] sig_set;
  logic                      power_on;
  logic                      sig_read;
  logic                      vel_over;
  logic                      tune_over;
  logic [VEL_W:0]            tune_sum;
  logic                      tune_ev;

  // A tuning overrun only counts while tuning runs, so a stray pulse in normal motion is ignored.
  assign tune_ev = ev_tune_range && drive.tuning_active;

  // Only these two states have the power stage switched on.
  assign power_on = (drive.state == dcc_pkg::DCC_ST_OP_ENABLED) ||
                    (drive.state == dcc_pkg::DCC_ST_QUICK_STOP);

  assign vel_over  = cmd_data.value_a[VEL_W-1:0] > vel_max;
  assign tune_sum  = {1'b0, cmd_data.value_a[VEL_W-1:0]} + {1'b0, cmd_data.value_b[VEL_W-1:0]};
  assign tune_over = tune_sum > {1'b0, tune_limit};

  // The checks run in a fixed order: the drive state first, then mode conflicts, then the values.
  always_comb begin
    next_resp.err_class = `DCC_CLASS_0;
    next_resp.code      = `DCC_ERR_NONE;
    if ((drive.state == dcc_pkg::DCC_ST_FAULT) || (drive.state == dcc_pkg::DCC_ST_FAULT_REACT)) begin
      next_resp.code = `DCC_ERR_FAULT;
    end else if (cmd.need_op_enabled && (drive.state != dcc_pkg::DCC_ST_OP_ENABLED)) begin
      next_resp.code = `DCC_ERR_NOT_OPEN;
    end else if (cmd.need_power && !power_on) begin
      next_resp.code = `DCC_ERR_PWR_OFF;
    end else if (cmd.forbid_homing && drive.homing_active) begin
      next_resp.code = `DCC_ERR_HOMING;
    end else if (cmd.forbid_halt && drive.halt_pending) begin
      next_resp.code = `DCC_ERR_HALT;
    end else if (cmd.new_mode && !drive.motion_done) begin
      next_resp.code = `DCC_ERR_MODE_BUSY;
    end else if ((cmd.need_standstill || cmd.set_limits || cmd.set_zero) && !drive.motion_done) begin
      next_resp.code = `DCC_ERR_MOVING;
    end else if (cmd.need_zero && !zero_valid) begin
      next_resp.code = `DCC_ERR_NO_ZERO;
    end else if (cmd.is_move && !cmd.dir_neg && drive.swlim_pos_hit) begin
      next_resp.code      = `DCC_ERR_SWLIM_POS;
      next_resp.err_class = `DCC_CLASS_1;
    end else if (cmd.is_move && cmd.dir_neg && drive.swlim_neg_hit) begin
      next_resp.code      = `DCC_ERR_SWLIM_NEG;
      next_resp.err_class = `DCC_CLASS_1;
    end else if (cmd.set_limits && (cmd_data.value_b > cmd_data.value_a)) begin
      // value_a holds the positive limit and value_b the negative one.
      next_resp.code = `DCC_ERR_LIM_ORDER;
    end else if (cmd.set_vel && vel_over) begin
      next_resp.code = `DCC_ERR_VEL_MAX;
    end else if (cmd.set_tuning && tune_over) begin
      next_resp.code = `DCC_ERR_TUNE_AMPL;
    end
  end

  // Every command gets an answer one cycle later; a zero code means accepted.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      resp_valid <= 1'b0;
      resp       <= '0;
    end else begin
      resp_valid <= cmd_valid;
      if (cmd_valid) begin
        resp <= next_resp;
      end
    end
  end

  // Asynchronous events report an error of their own; the range overrun has the highest priority.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      event_valid <= 1'b0;
      event_err   <= '0;
    end else begin
      event_valid <= ev_range_exceeded || tune_ev || ev_pos_dev || ev_home_fail;
      if (ev_range_exceeded) begin
        event_err <= '{code: `DCC_ERR_RANGE_LOST, err_class: `DCC_CLASS_0};
      end else if (ev_pos_dev) begin
        event_err <= '{code: `DCC_ERR_POS_DEV, err_class: position_deviation_response};
      end else if (ev_home_fail) begin
        event_err <= '{code: `DCC_ERR_HOME_FAIL, err_class: `DCC_CLASS_1};
      end else if (tune_ev) begin
        event_err <= '{code: `DCC_ERR_TUNE_RANGE, err_class: `DCC_CLASS_1};
      end
    end
  end

  // A range overrun wins over a zero point set by homing in the same cycle, since the position is then unsure.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      zero_valid <= 1'b0;
    end else if (ev_range_exceeded) begin
      zero_valid <= 1'b0;
    end else if (ev_home_done) begin
      zero_valid <= 1'b1;
    end else if (reg_wr && (reg_addr == `DCC_REG_ZERO_SET) && reg_wdata[0] && drive.motion_done) begin
      zero_valid <= 1'b1;
    end
  end

  // Software limit stops are refused commands, but still latch bit 2.
  always_comb begin
    sig_set = '0;
    sig_set[`DCC_SIG_BIT_LIMIT] = tune_ev ||
                                  (cmd_valid && ((next_resp.code == `DCC_ERR_SWLIM_POS) ||
                                                 (next_resp.code == `DCC_ERR_SWLIM_NEG)));
    sig_set[`DCC_SIG_BIT_HOME]  = ev_home_fail;
    sig_set[`DCC_SIG_BIT_PDEV]  = ev_pos_dev;
  end

  assign sig_read = reg_rd && (reg_addr == `DCC_REG_SIG);

  // Read clears the word, but a bit set in the same cycle survives.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      latched_signal_status <= `DCC_SIG_RESET;
    end else if (sig_read) begin
      latched_signal_status <= sig_set;
    end else begin
      latched_signal_status <= latched_signal_status | sig_set;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      home_sub_err <= '0;
    end else if (ev_home_fail && (ev_home_sub >= `DCC_SUB_FIRST) && (ev_home_sub <= `DCC_SUB_LAST)) begin
      home_sub_err <= ev_home_sub;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sig_mask                    <= '0;
      position_deviation_response <= `DCC_CLASS_PDEV_RST;
    end else if (reg_wr) begin
      if (reg_addr == `DCC_REG_MASK) begin
        sig_mask <= reg_wdata;
      end
      if (reg_addr == `DCC_REG_CLASS_PDEV) begin
        position_deviation_response <= reg_wdata[2:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `DCC_REG_SIG:        reg_rdata <= latched_signal_status;
        `DCC_REG_MASK:       reg_rdata <= sig_mask;
        `DCC_REG_CLASS_PDEV: reg_rdata <= {29'h0000_0000, position_deviation_response};
        `DCC_REG_SUBERR:     reg_rdata <= {16'h0000, home_sub_err};
        `DCC_REG_ZERO_SET:   reg_rdata <= {31'h0000_0000, zero_valid};
        default:             reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  assign irq = |(latched_signal_status & sig_mask);

  a_fault_reject: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cmd_valid && (drive.state == dcc_pkg::DCC_ST_FAULT)) |=> (resp.code == `DCC_ERR_FAULT && resp_valid))
    else $error("fault state did not answer A308");
  a_not_enabled: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cmd_valid && cmd.need_op_enabled && drive.state == dcc_pkg::DCC_ST_SWITCH_ON) |=>
    (resp.code == `DCC_ERR_NOT_OPEN))
    else $error("missing A309");
  a_power_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cmd_valid && !cmd.need_op_enabled && cmd.need_power && drive.state == dcc_pkg::DCC_ST_SWITCH_ON) |=>
    (resp.code == `DCC_ERR_PWR_OFF))
    else $error("missing A310");
  a_zero_lost: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ev_range_exceeded |=> (!zero_valid && event_valid && event_err.code == `DCC_ERR_RANGE_LOST))
    else $error("range overrun kept zero point");

  a_no_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (resp_valid && resp.code == `DCC_ERR_NONE) |-> !$past(cmd.need_zero && !zero_valid))
    else $error("command accepted without zero point");

  a_accept_ok: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cmd_valid |=> resp_valid ##1 (resp_valid == $past(cmd_valid)))
    else $error("answer not one cycle after command");

  // The class register may be written in the event cycle, so the class is judged against the old value.
  a_pdev_latch: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ev_pos_dev && !ev_range_exceeded) |=> latched_signal_status[`DCC_SIG_BIT_PDEV] &&
    event_err.code == `DCC_ERR_POS_DEV && event_err.err_class == $past(position_deviation_response))
    else $error("deviation not latched");

  a_home_latch: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ev_home_fail && !ev_range_exceeded && !ev_pos_dev) |=>
    (latched_signal_status[`DCC_SIG_BIT_HOME] && event_err.code == `DCC_ERR_HOME_FAIL))
    else $error("homing error not latched");

  // The blocking checks from a_homing_busy to a_tune_ampl, except a_swlim_latch, ask only that the command is refused, since an earlier check may win.
  a_fault_react: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cmd_valid && drive.state == dcc_pkg::DCC_ST_FAULT_REACT) |=>
    (resp.code == `DCC_ERR_FAULT && resp.err_class == `DCC_CLASS_0))
    else $error("fault reaction did not answer A308");

  a_fault_class: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cmd_valid && drive.state == dcc_pkg::DCC_ST_FAULT) |=>
    (resp.err_class == `DCC_CLASS_0))
    else $error("fault answer has wrong class");

  a_quick_stop_on: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cmd_valid && drive.state == dcc_pkg::DCC_ST_QUICK_STOP) |=>
    (resp.code != `DCC_ERR_PWR_OFF))
    else $error("quick stop treated as power off");

  a_homing_busy: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cmd_valid && cmd.forbid_homing && drive.homing_active) |=>
    (resp.code != `DCC_ERR_NONE))
    else $error("command accepted during homing");

  a_halt_busy: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cmd_valid && cmd.forbid_halt && drive.halt_pending) |=>
    (resp.code != `DCC_ERR_NONE))
    else $error("command accepted during halt");

  a_mode_busy: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cmd_valid && cmd.new_mode && !drive.motion_done) |=>
    (resp.code != `DCC_ERR_NONE))
    else $error("new mode accepted while busy");

  a_not_still: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cmd_valid && (cmd.need_standstill || cmd.set_limits || cmd.set_zero) && !drive.motion_done) |=>
    (resp.code != `DCC_ERR_NONE))
    else $error("command accepted while moving");

  a_swlim_pos: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cmd_valid && cmd.is_move && !cmd.dir_neg && drive.swlim_pos_hit) |=>
    (resp.code != `DCC_ERR_NONE))
    else $error("move past positive limit accepted");

  a_swlim_neg: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cmd_valid && cmd.is_move && cmd.dir_neg && drive.swlim_neg_hit) |=>
    (resp.code != `DCC_ERR_NONE))
    else $error("move past negative limit accepted");

  a_swlim_latch: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (resp_valid && (resp.code == `DCC_ERR_SWLIM_POS || resp.code == `DCC_ERR_SWLIM_NEG)) |->
    (latched_signal_status[`DCC_SIG_BIT_LIMIT] && resp.err_class == `DCC_CLASS_1))
    else $error("limit stop not latched");

  a_lim_order: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cmd_valid && cmd.set_limits && (cmd_data.value_b > cmd_data.value_a)) |=>
    (resp.code != `DCC_ERR_NONE))
    else $error("crossed limits accepted");

  a_vel_max: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cmd_valid && cmd.set_vel && (cmd_data.value_a[VEL_W-1:0] > vel_max)) |=>
    (resp.code != `DCC_ERR_NONE))
    else $error("velocity above maximum accepted");

  a_tune_ampl: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cmd_valid && cmd.set_tuning && tune_over) |=>
    (resp.code != `DCC_ERR_NONE))
    else $error("tuning amplitude accepted");

  a_tune_latch: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ev_tune_range && drive.tuning_active) |=>
    latched_signal_status[`DCC_SIG_BIT_LIMIT])
    else $error("tuning overrun not latched");

  a_tune_class: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (tune_ev && !ev_range_exceeded && !ev_pos_dev && !ev_home_fail) |=>
    (event_err.code == `DCC_ERR_TUNE_RANGE && event_err.err_class == `DCC_CLASS_1))
    else $error("tuning overrun reported wrongly");

  a_tune_idle: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ev_tune_range && !drive.tuning_active && !ev_range_exceeded && !ev_pos_dev && !ev_home_fail) |=>
    !event_valid)
    else $error("overrun reported outside tuning");

  a_home_sub: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ev_home_fail && ev_home_sub >= `DCC_SUB_FIRST && ev_home_sub <= `DCC_SUB_LAST) |=>
    (home_sub_err == $past(ev_home_sub)))
    else $error("homing sub-error not stored");

  a_home_class: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ev_home_fail && !ev_range_exceeded && !ev_pos_dev) |=>
    (event_err.err_class == `DCC_CLASS_1))
    else $error("homing error has wrong class");

  a_range_class: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ev_range_exceeded |=>
    (event_err.err_class == `DCC_CLASS_0))
    else $error("range overrun has wrong class");

  a_zero_home: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ev_home_done && !ev_range_exceeded) |=>
    zero_valid)
    else $error("homing did not set zero point");

  a_event_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!ev_range_exceeded && !ev_tune_range && !ev_pos_dev && !ev_home_fail) |=>
    !event_valid)
    else $error("event reported without cause");

  a_resp_idle: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !cmd_valid |=>
    !resp_valid)
    else $error("answer without command");

endmodule : dcc_checker

/* File: design/dcc_map.svh */
/*
 * Constants of the drive command checker: error codes, classes, status bit positions, field widths.
 * Assumes it is included once per compilation unit by its bare name.
 */
`ifndef DCC_MAP_SVH
`define DCC_MAP_SVH

`define DCC_ERR_NONE       16'h0000
`define DCC_ERR_FAULT      16'hA308
`define DCC_ERR_NOT_OPEN   16'hA309
`define DCC_ERR_PWR_OFF    16'hA310
`define DCC_ERR_RANGE_LOST 16'hA313
`define DCC_ERR_NO_ZERO    16'hA314
`define DCC_ERR_HOMING     16'hA315
`define DCC_ERR_MOVING     16'hA317
`define DCC_ERR_MODE_BUSY  16'hA318
`define DCC_ERR_TUNE_RANGE 16'hA319
`define DCC_ERR_TUNE_AMPL  16'hA31A
`define DCC_ERR_HALT       16'hA31B
`define DCC_ERR_LIM_ORDER  16'hA31C
`define DCC_ERR_VEL_MAX    16'hA31D
`define DCC_ERR_SWLIM_POS  16'hA31E
`define DCC_ERR_SWLIM_NEG  16'hA31F
`define DCC_ERR_POS_DEV    16'hA320
`define DCC_ERR_HOME_FAIL  16'hA324
`define DCC_SUB_FIRST      16'hA325
`define DCC_SUB_LAST       16'hA329

`define DCC_CLASS_0        3'h0
`define DCC_CLASS_1        3'h1

`define DCC_SIG_BIT_LIMIT  2
`define DCC_SIG_BIT_HOME   10
`define DCC_SIG_BIT_PDEV   22
`define DCC_SIG_WIDTH      32
`define DCC_SIG_RESET      32'h0000_0000

`define DCC_REG_SIG        4'h0
`define DCC_REG_MASK       4'h1
`define DCC_REG_CLASS_PDEV 4'h2
`define DCC_REG_SUBERR     4'h3
`define DCC_REG_ZERO_SET   4'h4
`define DCC_REG_LAST       4'h5
`define DCC_CLASS_PDEV_RST 3'h1

`endif

/* File: design/dcc_pkg.sv */
/*
 * Types of the drive command checker.
 * Assumes the constants header is included by the files that use the numbers.
 */
package dcc_pkg;

  typedef enum logic [2:0] {
    DCC_ST_NOT_READY   = 3'b000,
    DCC_ST_SWITCH_ON   = 3'b001,
    DCC_ST_OP_ENABLED  = 3'b010,
    DCC_ST_QUICK_STOP  = 3'b011,
    DCC_ST_FAULT_REACT = 3'b100,
    DCC_ST_FAULT       = 3'b101
  } dcc_state_t;

  // What a command needs before it may run.
  typedef struct packed {
    logic need_op_enabled;
    logic need_power;
    logic need_zero;
    logic forbid_homing;
    logic need_standstill;
    logic new_mode;
    logic forbid_halt;
    logic is_move;
    logic dir_neg;
    logic set_vel;
    logic set_limits;
    logic set_tuning;
    logic set_zero;
  } dcc_cmd_t;

  typedef struct packed {
    logic signed [31:0] value_a;
    logic signed [31:0] value_b;
  } dcc_data_t;

  typedef struct packed {
    logic [15:0] code;
    logic [2:0]  err_class;
  } dcc_resp_t;

  typedef struct packed {
    dcc_state_t state;
    logic       homing_active;
    logic       halt_pending;
    logic       motion_done;
    logic       tuning_active;
    logic       swlim_pos_hit;
    logic       swlim_neg_hit;
  } dcc_drive_t;

endpackage : dcc_pkg

/* File: verif/dcc_host_model.sv */
/*
 * Fieldbus-side command source for the drive command checker.
 * Assumes the bench calls send from one process and the checker samples commands on rising edges.
 */
`timescale 1ns/1ps

module dcc_host_model (
  // Clock.
  input  wire logic          clk_sys,
  // Command out.
  output dcc_pkg::dcc_cmd_t  cmd,
  output dcc_pkg::dcc_data_t cmd_data,
  output logic               cmd_valid
);
  initial begin
    cmd_valid = 1'b0;
    cmd       = '0;
    cmd_data  = '0;
  end

  // Outside a command the fields show the inverse of the last one, so a stale sample never passes.
  task automatic send(input dcc_pkg::dcc_cmd_t c, input dcc_pkg::dcc_data_t d);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd       <= c;
    cmd_data  <= d;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd       <= ~c;
    cmd_data  <= ~d;
  endtask : send
endmodule : dcc_host_model

/* File: verif/drive_command_checker_bench.sv */
/*
 * Self-checking bench of the drive command checker: commands, events, status word and interrupt.
 * Assumes dcc_host_model stands for the fieldbus side and every input moves on a rising edge.
 */
`timescale 1ns/1ps
`include "dcc_map.svh"

module drive_command_checker_bench;
  logic                clk_sys;
  logic                arst_n;
  dcc_pkg::dcc_cmd_t   cmd;
  dcc_pkg::dcc_data_t  cmd_data;
  logic                cmd_valid;
  logic                resp_valid;
  dcc_pkg::dcc_resp_t  resp;
  dcc_pkg::dcc_drive_t drive;
  logic [31:0]         vel_max;
  logic [31:0]         tune_limit;
  logic [4:0]          evs;
  logic [15:0]         ev_home_sub;
  logic                event_valid;
  dcc_pkg::dcc_resp_t  event_err;
  logic                zero_valid;
  logic                irq;
  logic [3:0]          reg_addr;
  logic [31:0]         reg_wdata;
  logic                reg_wr;
  logic                reg_rd;
  logic [31:0]         reg_rdata;
  logic [31:0]         rd;
  int                  failures;
  int                  n_checks;

  always #50 clk_sys = ~clk_sys;

  dcc_host_model i_host (.clk_sys(clk_sys), .cmd(cmd), .cmd_data(cmd_data), .cmd_valid(cmd_valid));

  dcc_checker #(.VEL_W(32)) i_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_data(cmd_data),
    .resp_valid(resp_valid), .resp(resp), .drive(drive), .vel_max(vel_max), .tune_limit(tune_limit),
    .ev_range_exceeded(evs[0]), .ev_tune_range(evs[1]), .ev_pos_dev(evs[2]), .ev_home_fail(evs[3]),
    .ev_home_sub(ev_home_sub), .ev_home_done(evs[4]), .event_valid(event_valid), .event_err(event_err),
    .zero_valid(zero_valid), .irq(irq), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    $display("checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    #1;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask : reg_read

  task automatic set_drive(input dcc_pkg::dcc_drive_t d);
    @(posedge clk_sys);
    drive <= d;
  endtask : set_drive

  // Flag order from the top: op_enabled, power, zero, homing, standstill, new_mode, halt, move, neg,
  // vel, limits, tuning, set_zero.
  task automatic cmd_case(input logic [12:0] c, input logic [31:0] a, input logic [31:0] b,
                          input logic [15:0] code, input logic [2:0] cls);
    i_host.send(c, {a, b});
    #1;
    check(resp_valid, 1'b1);
    check(resp.code, code);
    check(resp.err_class, cls);
  endtask : cmd_case

  task automatic pulse(input logic [4:0] v);
    @(posedge clk_sys);
    evs <= v;
    @(posedge clk_sys);
    evs <= 5'h00;
    #1;
  endtask : pulse

  task automatic ev_check(input logic [15:0] code, input logic [2:0] cls);
    check(event_valid, 1'b1);
    check(event_err.code, code);
    check(event_err.err_class, cls);
  endtask : ev_check

  // Drive word: state, homing, halt, motion_done, tuning, pos limit hit, neg limit hit.
  task automatic test_states;
    set_drive(9'h148);
    cmd_case(13'h0000, 32'h0, 32'h0, `DCC_ERR_FAULT, `DCC_CLASS_0);
    set_drive(9'h108);
    cmd_case(13'h1800, 32'h0, 32'h0, `DCC_ERR_FAULT, `DCC_CLASS_0);
    set_drive(9'h008);
    cmd_case(13'h1000, 32'h0, 32'h0, `DCC_ERR_NOT_OPEN, `DCC_CLASS_0);
    set_drive(9'h048);
    cmd_case(13'h0800, 32'h0, 32'h0, `DCC_ERR_PWR_OFF, `DCC_CLASS_0);
    set_drive(9'h0C8);
    cmd_case(13'h0800, 32'h0, 32'h0, `DCC_ERR_NONE, `DCC_CLASS_0);
    cmd_case(13'h1000, 32'h0, 32'h0, `DCC_ERR_NOT_OPEN, `DCC_CLASS_0);
    set_drive(9'h088);
    cmd_case(13'h1800, 32'h0, 32'h0, `DCC_ERR_NONE, `DCC_CLASS_0);
    $display("test_states done");
  endtask : test_states

  task automatic test_gates;
    set_drive(9'h0A8);
    cmd_case(13'h0200, 32'h0, 32'h0, `DCC_ERR_HOMING, `DCC_CLASS_0);
    set_drive(9'h098);
    cmd_case(13'h0040, 32'h0, 32'h0, `DCC_ERR_HALT, `DCC_CLASS_0);
    set_drive(9'h088);
    cmd_case(13'h0240, 32'h0, 32'h0, `DCC_ERR_NONE, `DCC_CLASS_0);
    set_drive(9'h080);
    cmd_case(13'h0080, 32'h0, 32'h0, `DCC_ERR_MODE_BUSY, `DCC_CLASS_0);
    cmd_case(13'h0001, 32'h0, 32'h0, `DCC_ERR_MOVING, `DCC_CLASS_0);
    cmd_case(13'h0004, 32'h0, 32'h1, `DCC_ERR_MOVING, `DCC_CLASS_0);
    cmd_case(13'h0100, 32'h0, 32'h0, `DCC_ERR_MOVING, `DCC_CLASS_0);
    set_drive(9'h088);
    cmd_case(13'h0400, 32'h0, 32'h0, `DCC_ERR_NO_ZERO, `DCC_CLASS_0);
    reg_write(4'h4, 32'h0000_0001);
    check(zero_valid, 1'b1);
    cmd_case(13'h0400, 32'h0, 32'h0, `DCC_ERR_NONE, `DCC_CLASS_0);
    $display("test_gates done");
  endtask : test_gates

  task automatic test_values;
    set_drive(9'h08A);
    cmd_case(13'h0020, 32'h0, 32'h0, `DCC_ERR_SWLIM_POS, `DCC_CLASS_1);
    cmd_case(13'h0030, 32'h0, 32'h0, `DCC_ERR_NONE, `DCC_CLASS_0);
    set_drive(9'h089);
    cmd_case(13'h0030, 32'h0, 32'h0, `DCC_ERR_SWLIM_NEG, `DCC_CLASS_1);
    cmd_case(13'h0020, 32'h0, 32'h0, `DCC_ERR_NONE, `DCC_CLASS_0);
    set_drive(9'h088);
    reg_read(4'h0);
    check(rd, 32'h0000_0004);
    cmd_case(13'h0004, 32'hFFFF_FFFF, 32'h0, `DCC_ERR_LIM_ORDER, `DCC_CLASS_0);
    cmd_case(13'h0004, 32'hA, 32'hA, `DCC_ERR_NONE, `DCC_CLASS_0);
    cmd_case(13'h0008, 32'h65, 32'h0, `DCC_ERR_VEL_MAX, `DCC_CLASS_0);
    cmd_case(13'h0008, 32'h64, 32'h0, `DCC_ERR_NONE, `DCC_CLASS_0);
    cmd_case(13'h0002, 32'h1E, 32'h15, `DCC_ERR_TUNE_AMPL, `DCC_CLASS_0);
    cmd_case(13'h0002, 32'h1E, 32'h14, `DCC_ERR_NONE, `DCC_CLASS_0);
    $display("test_values done");
  endtask : test_values

  task automatic test_events;
    set_drive(9'h08C);
    reg_read(4'h2);
    check(rd, 32'h0000_0001);
    reg_write(4'h2, 32'h0000_0003);
    pulse(5'h03);
    ev_check(`DCC_ERR_RANGE_LOST, `DCC_CLASS_0);
    check(zero_valid, 1'b0);
    pulse(5'h04);
    ev_check(`DCC_ERR_POS_DEV, 3'h3);
    pulse(5'h08);
    ev_check(`DCC_ERR_HOME_FAIL, `DCC_CLASS_1);
    reg_read(4'h3);
    check(rd, 32'h0000_A327);
    pulse(5'h02);
    ev_check(`DCC_ERR_TUNE_RANGE, `DCC_CLASS_1);
    reg_read(4'h0);
    check(rd, 32'h0040_0404);
    reg_read(4'h0);
    check(rd, 32'h0000_0000);
    pulse(5'h10);
    check(zero_valid, 1'b1);
    reg_read(4'h7);
    check(rd, 32'h0000_0000);
    $display("test_events done");
  endtask : test_events

  task automatic test_irq;
    reg_write(4'h1, 32'h0040_0000);
    check(irq, 1'b0);
    pulse(5'h04);
    check(irq, 1'b1);
    reg_write(4'h1, 32'h0000_0000);
    check(irq, 1'b0);
    reg_write(4'h1, 32'h0040_0000);
    check(irq, 1'b1);
    reg_read(4'h0);
    check(irq, 1'b0);
    $display("test_irq done");
  endtask : test_irq

  initial begin
    clk_sys     = 1'b0;
    arst_n      = 1'b0;
    drive       = 9'h008;
    vel_max     = 32'h0000_0064;
    tune_limit  = 32'h0000_0032;
    evs         = 5'h00;
    ev_home_sub = 16'hA327;
    reg_addr    = 4'h0;
    reg_wdata   = 32'h0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    failures    = 0;
    n_checks    = 0;
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    test_states;
    test_gates;
    test_values;
    test_events;
    test_irq;
    conclude;
  end

  // The tests need about 120 cycles; two thousand means a hang.
  initial begin
    #200000;
    failures++;
    conclude;
  end
endmodule : drive_command_checker_bench
